/* File: ocg_pkg.sv */
/*
  Shared constants and types for the oscillator and clock generator block.
  Assumes a 20 MHz APB clock and byte-wide registers, one per aligned word.
*/
package ocg_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [15:0] IDX_SRC = 16'h5060;
  localparam logic [15:0] IDX_CTL = 16'h5061;
  localparam logic [15:0] IDX_NFEN = 16'h5062;
  localparam logic [15:0] IDX_LCLK = 16'h5063;
  localparam logic [15:0] IDX_FOUT = 16'h5064;
  localparam logic [15:0] IDX_TMR = 16'h5065;
  localparam logic [15:0] IDX_STAT = 16'h5066;
  localparam logic [15:0] IDX_PCLK = 16'h5080;
  localparam logic [15:0] IDX_CPU_CLOCK = 16'h5081;

  function automatic logic [31:0] byte_addr(input logic [15:0] idx);
    return {14'h0000, idx, 2'h0};
  endfunction

  // Writable bits of each register; all others read as zero
  localparam logic [7:0] MASK_SRC = 8'h01;
  localparam logic [7:0] MASK_CTL = 8'h33;
  localparam logic [7:0] MASK_NFEN = 8'h03;
  localparam logic [7:0] MASK_LCLK = 8'h1f;
  localparam logic [7:0] MASK_FOUT = 8'h0f;
  localparam logic [7:0] MASK_TMR = 8'h0f;
  localparam logic [7:0] MASK_PCLK = 8'h03;
  localparam logic [7:0] MASK_CPU_CLOCK = 8'h03;

  localparam logic [7:0] RST_SRC = 8'h00;
  localparam logic [7:0] RST_CTL = 8'h03;
  localparam logic [7:0] RST_NFEN = 8'h02;
  localparam logic [7:0] RST_LCLK = 8'h02;
  localparam logic [7:0] RST_FOUT = 8'h00;
  localparam logic [7:0] RST_TMR = 8'h00;
  localparam logic [7:0] RST_PCLK = 8'h03;
  localparam logic [7:0] RST_CPU_CLOCK = 8'h00;

  // Field positions
  localparam int SRC_SEL_BIT = 0;
  localparam int WAIT_LSB = 4;
  localparam int SUB_EN_BIT = 1;
  localparam int MAIN_EN_BIT = 0;
  localparam int RST_FE_BIT = 1;
  localparam int NMI_FE_BIT = 0;
  localparam int LCD_DIV_LSB = 2;
  localparam int LCD_SRC_BIT = 1;
  localparam int LCD_EN_BIT = 0;
  localparam int FOUT_DIV_LSB = 2;
  localparam int FOUT_EN_BIT = 1;
  localparam int SLOW_OUT_EN_BIT = 0;
  localparam int TMR_DIV_LSB = 1;
  localparam int TMR_EN_BIT = 0;
  localparam int STAT_READY_BIT = 0;

  // Field codes
  localparam logic [2:0] LCD_DIV_MAX = 3'h4;
  localparam logic [1:0] FOUT_DIV_MAX = 2'h2;
  localparam logic [2:0] TMR_DIV_MAX = 3'h5;
  localparam logic [1:0] PCLK_ON = 2'h3;
  localparam logic [3:0] LCD_DIV_BASE = 4'h5;

  // Divider and wait counters
  localparam int DIV_CNT_W = 9;
  localparam int WAIT_W = 11;
  localparam logic [WAIT_W-1:0] WAIT_LONGEST = 11'h400;

  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int FILTER_NS = 200;
  localparam int FILTER_CYCLES_I = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] FILTER_LAST = 4'(FILTER_CYCLES_I - 1);

  typedef struct packed {
    logic [7:0] src;
    logic [7:0] ctl;
    logic [7:0] nfen;
    logic [7:0] lclk;
    logic [7:0] fout;
    logic [7:0] tmr;
    logic [7:0] pclk;
    logic [7:0] cpu_clock;
  } ocg_regs_t;

  typedef struct packed {
    logic sys;
    logic cpu;
    logic periph;
    logic lcd;
    logic fast_out;
    logic slow_out;
    logic slow_timer;
  } ocg_clocks_t;

endpackage

/* File: ocg_sync.sv */
/*
  Two-flop synchroniser for one level.
  Assumes the input is asynchronous to pclk; only q is read outside.
*/
module ocg_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic d,
  output logic q
);
  logic meta;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= 1'b0;
      q <= 1'b0;
    end else if (ce) begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

/* File: ocg_div.sv */
/*
  Power-of-two divider of a sampled clock level.
  Assumes src_rise pulses once per source rising edge and shift stays within the counter.
*/
module ocg_div (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic src_level,
  input wire logic src_rise,
  input wire logic [3:0] shift,
  output logic div_level
);
  import ocg_pkg::*;

  logic [DIV_CNT_W-1:0] cnt;

  // Bit k-1 of an edge counter has a period of 2^k source periods
  assign div_level = (shift == 4'h0) ? src_level : cnt[shift - 4'h1];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
    end else if (ce && src_rise) begin
      cnt <= cnt + 9'h001;
    end
  end
endmodule

/* File: ocg_top.sv */
/*
  Oscillator and clock generator control: APB registers, oscillator enables,
  stabilisation wait, clock selection, dividers and gates, reset and NMI noise filters.
  Assumes oscillator and pin inputs are asynchronous and much slower than pclk;
  generated clocks are sampled levels, fine for slow loads and observation.
*/
// Added by the designer: the APB register port.
module ocg_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic main_osc_in,
  input wire logic sub_osc_in,
  input wire logic ext_reset_n_in,
  input wire logic nmi_in,
  output logic main_osc_enable,
  output logic sub_osc_enable,
  output logic main_osc_ready,
  output ocg_pkg::ocg_clocks_t clocks,
  output logic reset_n_filtered,
  output logic nmi_filtered
);
  import ocg_pkg::*;

  function automatic logic [WAIT_W-1:0] wait_cycles(input logic [1:0] code);
    return WAIT_LONGEST >> code;
  endfunction

  function automatic logic [7:0] masked(input logic [7:0] d, input logic [7:0] m);
    return d & m;
  endfunction

  ocg_regs_t regs;
  logic main_s, sub_s, rst_s, nmi_s;
  logic main_d, sub_d;
  logic [WAIT_W-1:0] wait_cnt;
  logic [3:0] rst_fcnt, nmi_fcnt;

  ocg_sync u_sync_main (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .d(main_osc_in),
    .q(main_s)
  );
  ocg_sync u_sync_sub (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .d(sub_osc_in),
    .q(sub_s)
  );
  ocg_sync u_sync_rst (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .d(ext_reset_n_in),
    .q(rst_s)
  );
  ocg_sync u_sync_nmi (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .d(nmi_in),
    .q(nmi_s)
  );

  // Field views
  wire src_sel = regs.src[SRC_SEL_BIT];
  wire [1:0] main_wait = regs.ctl[WAIT_LSB +: 2];
  wire sub_en = regs.ctl[SUB_EN_BIT];
  wire main_en = regs.ctl[MAIN_EN_BIT];
  wire rst_fe = regs.nfen[RST_FE_BIT];
  wire nmi_fe = regs.nfen[NMI_FE_BIT];
  wire [2:0] lcd_div = regs.lclk[LCD_DIV_LSB +: 3];
  wire lcd_sel = regs.lclk[LCD_SRC_BIT];
  wire lcd_en = regs.lclk[LCD_EN_BIT];
  wire [1:0] fout_div = regs.fout[FOUT_DIV_LSB +: 2];
  wire fout_en = regs.fout[FOUT_EN_BIT];
  wire slow_out_en = regs.fout[SLOW_OUT_EN_BIT];
  wire [2:0] tmr_div = regs.tmr[TMR_DIV_LSB +: 3];
  wire tmr_en = regs.tmr[TMR_EN_BIT];
  wire [1:0] pclk_gate = regs.pclk[1:0];
  wire [1:0] gear = regs.cpu_clock[1:0];

  wire main_rise = main_s & ~main_d;
  wire sub_rise = sub_s & ~sub_d;

  // Main oscillator is invisible downstream until its wait is over
  wire main_gated = main_osc_ready & main_s;
  wire main_gated_rise = main_osc_ready & main_rise;
  wire sys_level = src_sel ? sub_s : main_gated;
  wire sys_rise = src_sel ? sub_rise : main_gated_rise;
  wire wait_done = (wait_cnt + 11'h001) >= wait_cycles(main_wait);

  wire cpu_div, lcd_main_div, fout_div_level, tmr_div_level;

  ocg_div u_div_cpu (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .src_level(sys_level),
    .src_rise(sys_rise),
    .shift({2'h0, gear}),
    .div_level(cpu_div)
  );
  ocg_div u_div_lcd (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .src_level(main_gated),
    .src_rise(main_gated_rise),
    .shift(LCD_DIV_BASE + {1'b0, lcd_div}),
    .div_level(lcd_main_div)
  );
  ocg_div u_div_fout (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .src_level(main_gated),
    .src_rise(main_gated_rise),
    .shift({2'h0, fout_div}),
    .div_level(fout_div_level)
  );
  ocg_div u_div_tmr (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .src_level(sub_s),
    .src_rise(sub_rise),
    .shift({1'b0, tmr_div}),
    .div_level(tmr_div_level)
  );

  // Reserved divider codes stop the clock rather than guess a ratio
  wire lcd_code_ok = lcd_sel | (lcd_div <= LCD_DIV_MAX);
  wire lcd_level = lcd_sel ? sub_s : lcd_main_div;
  ocg_clocks_t next_clocks;
  assign next_clocks.sys = sys_level;
  assign next_clocks.cpu = cpu_div;
  // Codes 1 and 2 are treated as off, the safe reading of a forbidden value
  assign next_clocks.periph = (pclk_gate == PCLK_ON) & sys_level;
  assign next_clocks.lcd = lcd_en & lcd_code_ok & lcd_level;
  assign next_clocks.fast_out = fout_en & (fout_div <= FOUT_DIV_MAX) & fout_div_level;
  assign next_clocks.slow_out = slow_out_en & sub_s;
  assign next_clocks.slow_timer = tmr_en & (tmr_div <= TMR_DIV_MAX) & tmr_div_level;

  // APB decode; one wait state lets read data come from a flop
  wire access = psel & penable;
  wire wr_en = access & pwrite & pready;
  wire hit_src = paddr == byte_addr(IDX_SRC);
  wire hit_ctl = paddr == byte_addr(IDX_CTL);
  wire hit_nfen = paddr == byte_addr(IDX_NFEN);
  wire hit_lclk = paddr == byte_addr(IDX_LCLK);
  wire hit_fout = paddr == byte_addr(IDX_FOUT);
  wire hit_tmr = paddr == byte_addr(IDX_TMR);
  wire hit_stat = paddr == byte_addr(IDX_STAT);
  wire hit_pclk = paddr == byte_addr(IDX_PCLK);
  wire hit_cpu_clock = paddr == byte_addr(IDX_CPU_CLOCK);
  wire hit_any = hit_src | hit_ctl | hit_nfen | hit_lclk | hit_fout | hit_tmr | hit_stat | hit_pclk | hit_cpu_clock;
  wire [7:0] stat_byte = {7'h00, main_osc_ready} << STAT_READY_BIT;
  wire [7:0] rd_byte = ({8{hit_src}} & regs.src) | ({8{hit_ctl}} & regs.ctl) | ({8{hit_nfen}} & regs.nfen)
    | ({8{hit_lclk}} & regs.lclk) | ({8{hit_fout}} & regs.fout) | ({8{hit_tmr}} & regs.tmr)
    | ({8{hit_stat}} & stat_byte) | ({8{hit_pclk}} & regs.pclk) | ({8{hit_cpu_clock}} & regs.cpu_clock);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      pready <= access & ~pready;
      pslverr <= access & ~pready & ~hit_any;
      prdata <= {24'h00_0000, rd_byte};
    end
  end

  // Only writable bits are stored, so reserved bits read as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      regs <= '{RST_SRC, RST_CTL, RST_NFEN, RST_LCLK, RST_FOUT, RST_TMR, RST_PCLK, RST_CPU_CLOCK};
    end else if (ce && wr_en) begin
      if (hit_src) regs.src <= masked(pwdata[7:0], MASK_SRC);
      if (hit_ctl) regs.ctl <= masked(pwdata[7:0], MASK_CTL);
      if (hit_nfen) regs.nfen <= masked(pwdata[7:0], MASK_NFEN);
      if (hit_lclk) regs.lclk <= masked(pwdata[7:0], MASK_LCLK);
      if (hit_fout) regs.fout <= masked(pwdata[7:0], MASK_FOUT);
      if (hit_tmr) regs.tmr <= masked(pwdata[7:0], MASK_TMR);
      if (hit_pclk) regs.pclk <= masked(pwdata[7:0], MASK_PCLK);
      if (hit_cpu_clock) regs.cpu_clock <= masked(pwdata[7:0], MASK_CPU_CLOCK);
    end
  end

  // Oscillator enables and stabilisation wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_osc_enable <= 1'b0;
      sub_osc_enable <= 1'b0;
      main_osc_ready <= 1'b0;
      wait_cnt <= '0;
      main_d <= 1'b0;
      sub_d <= 1'b0;
    end else if (ce) begin
      main_osc_enable <= main_en;
      sub_osc_enable <= sub_en;
      main_d <= main_s;
      sub_d <= sub_s;
      if (!main_en) begin
        main_osc_ready <= 1'b0;
        wait_cnt <= '0;
      end else if (!main_osc_ready && main_rise) begin
        wait_cnt <= wait_cnt + 11'h001;
        main_osc_ready <= wait_done;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clocks <= '0;
    end else if (ce) begin
      clocks <= next_clocks;
    end
  end

  // Noise filters: a change passes only after it has held for the filter time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_n_filtered <= 1'b0;
      nmi_filtered <= 1'b0;
      rst_fcnt <= 4'h0;
      nmi_fcnt <= 4'h0;
    end else if (ce) begin
      if (!rst_fe || rst_s == reset_n_filtered) begin
        reset_n_filtered <= rst_s;
        rst_fcnt <= 4'h0;
      end else if (rst_fcnt == FILTER_LAST) begin
        reset_n_filtered <= rst_s;
        rst_fcnt <= 4'h0;
      end else begin
        rst_fcnt <= rst_fcnt + 4'h1;
      end
      if (!nmi_fe || nmi_s == nmi_filtered) begin
        nmi_filtered <= nmi_s;
        nmi_fcnt <= 4'h0;
      end else if (nmi_fcnt == FILTER_LAST) begin
        nmi_filtered <= nmi_s;
        nmi_fcnt <= 4'h0;
      end else begin
        nmi_fcnt <= nmi_fcnt + 4'h1;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_held_off;
    ce && !src_sel && !main_osc_ready;
  endsequence

  sequence s_main_running;
    ce && main_en && main_osc_ready;
  endsequence

  a_sys_source: assert property (ce && src_sel |=> clocks.sys == $past(sub_s))
    else $error("system clock does not follow sub oscillator");
  a_wait_count: assert property ($rose(main_osc_ready) |-> wait_cnt == wait_cycles(main_wait))
    else $error("main oscillator ready after wrong wait count");
  a_sub_enable: assert property (ce |=> sub_osc_enable == $past(regs.ctl[SUB_EN_BIT]))
    else $error("sub oscillator enable not following register");
  a_main_stop: assert property (ce && !main_en |=> !main_osc_ready && !main_osc_enable)
    else $error("main oscillator still ready after disable");
  a_rst_filter: assert property (rst_fe && $changed(reset_n_filtered) |-> $past(rst_fcnt) == FILTER_LAST)
    else $error("reset filter passed a short pulse");
  a_nmi_bypass: assert property (ce && !nmi_fe |=> nmi_filtered == $past(nmi_s))
    else $error("nmi not passed straight when filter off");
  a_lcd_reserved: assert property (ce && !lcd_sel && lcd_div > LCD_DIV_MAX |=> !clocks.lcd)
    else $error("lcd clock runs on reserved divider");
  a_lcd_gate: assert property (ce && !lcd_en |=> !clocks.lcd)
    else $error("lcd clock not gated");
  a_fout_gate: assert property (ce && (!fout_en || fout_div > FOUT_DIV_MAX) |=> !clocks.fast_out)
    else $error("fast clock output not gated");
  a_slow_gate: assert property (ce && !slow_out_en |=> !clocks.slow_out)
    else $error("slow clock output not gated");
  a_timer_gate: assert property (ce && !tmr_en |=> !clocks.slow_timer)
    else $error("slow timer clock not gated");
  a_periph_gate: assert property (ce && pclk_gate != PCLK_ON |=> !clocks.periph)
    else $error("peripheral clock runs while gated");
  a_held_off: assert property (s_held_off |=> !clocks.sys && !clocks.periph)
    else $error("main clock delivered before wait ended");
  a_reserved_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h00_0000
    && (regs.lclk & ~MASK_LCLK) == 8'h00 && (regs.ctl & ~MASK_CTL) == 8'h00)
    else $error("reserved bits read nonzero");
  a_apb_answer: assert property (ce && access && !pready |=> pready)
    else $error("apb answer late");
  a_apb_pulse: assert property (ce && pready |=> !pready)
    else $error("apb answer longer than one cycle");
  a_unmapped_err: assert property (ce && access && !pready && !hit_any |=> pslverr)
    else $error("unmapped access not flagged");
  a_main_select: assert property (ce && !src_sel |=> clocks.sys == $past(main_osc_ready && main_s))
    else $error("system clock does not follow main oscillator");
  a_main_enable: assert property (ce |=> main_osc_enable == $past(regs.ctl[MAIN_EN_BIT]))
    else $error("main oscillator enable not following register");
  a_ready_hold: assert property (s_main_running |=> main_osc_ready)
    else $error("main oscillator ready dropped while enabled");
  a_rst_bypass: assert property (ce && !rst_fe |=> reset_n_filtered == $past(rst_s))
    else $error("reset not passed straight when filter off");
  a_nmi_filter: assert property (nmi_fe && $changed(nmi_filtered) |-> $past(nmi_fcnt) == FILTER_LAST)
    else $error("nmi filter passed a short pulse");
  a_lcd_sub: assert property (ce && lcd_en && lcd_sel |=> clocks.lcd == $past(sub_s))
    else $error("lcd clock does not follow sub oscillator");
  a_fout_direct: assert property (ce && fout_en && fout_div == '0
    |=> clocks.fast_out == $past(main_osc_ready && main_s))
    else $error("fast clock output not undivided for code 0");
  a_slow_follow: assert property (ce && slow_out_en |=> clocks.slow_out == $past(sub_s))
    else $error("slow clock output does not follow sub oscillator");
  a_timer_direct: assert property (ce && tmr_en && tmr_div == '0 |=> clocks.slow_timer == $past(sub_s))
    else $error("slow timer clock not undivided for code 0");
  a_periph_run: assert property (ce && pclk_gate == PCLK_ON |=> clocks.periph == clocks.sys)
    else $error("peripheral clock not supplied while enabled");
  a_cpu_direct: assert property (ce && gear == '0 |=> clocks.cpu == clocks.sys)
    else $error("cpu clock not undivided for gear 0");
endmodule

/* File: ocg_top_tb.sv */
/*
  Self-checking bench for the oscillator and clock generator block.
  Assumes ocg_pkg and ocg_top are compiled first; the bench makes both oscillators.
*/
module ocg_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ocg_pkg::*;

  typedef struct {logic rd; logic [31:0] d; logic e;} ocg_exp_t;

  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
  logic main_osc_in = 1'h0, sub_osc_in = 1'h0, ext_reset_n_in = 1'h1, nmi_in = 1'h0;
  logic ce = 1'h1;
  logic pready, pslverr, main_osc_enable, sub_osc_enable, main_osc_ready, reset_n_filtered, nmi_filtered;
  ocg_clocks_t clocks;
  logic [6:0] ck;
  int n_mismatch = 0, n_tests = 0, main_edges = 0, mc = 0, sc = 0;
  ocg_exp_t expq[$];
  ocg_exp_t e;
  logic [15:0] ia[8] = '{IDX_SRC, IDX_CTL, IDX_NFEN, IDX_LCLK, IDX_FOUT, IDX_TMR, IDX_PCLK, IDX_CPU_CLOCK};
  logic [7:0] ma[8] = '{MASK_SRC, MASK_CTL, MASK_NFEN, MASK_LCLK, MASK_FOUT, MASK_TMR, MASK_PCLK, MASK_CPU_CLOCK};
  logic [7:0] ra[8] = '{8'h00, 8'h03, 8'h02, 8'h02, 8'h00, 8'h00, 8'h03, 8'h00};

  assign ck = clocks;

  always #25 pclk = ~pclk;

  ocg_top DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .main_osc_in(main_osc_in), .sub_osc_in(sub_osc_in), .ext_reset_n_in(ext_reset_n_in), .nmi_in(nmi_in),
    .main_osc_enable(main_osc_enable), .sub_osc_enable(sub_osc_enable), .main_osc_ready(main_osc_ready),
    .clocks(clocks), .reset_n_filtered(reset_n_filtered), .nmi_filtered(nmi_filtered));

  // Main oscillator period 6 cycles, sub oscillator period 16 cycles
  // Each runs only while the block enables it and rests low when stopped
  always @(posedge pclk) begin
    mc <= (mc == 2) ? 0 : mc + 1;
    sc <= (sc == 7) ? 0 : sc + 1;
    if (mc == 2) begin
      main_osc_in <= ~main_osc_in & main_osc_enable;
      if (!main_osc_in && main_osc_enable) main_edges <= main_edges + 1;
    end
    if (sc == 7) sub_osc_in <= ~sub_osc_in & sub_osc_enable;
  end

  task automatic stop_test();
    if (n_mismatch == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Expected answer is queued before the request; the monitor below compares it
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd, input logic [7:0] rd,
                     input logic err);
    int i;
    expq.push_back('{!wr, {24'h0, rd}, err});
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= {14'h0, idx, 2'h0};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'h1) break;
    end
    psel <= 1'h0;
    penable <= 1'h0;
    if (i == 16) begin
      chk("pready wait", 32'h0, 32'h1);
      stop_test();
    end
  endtask

  always @(posedge pclk) begin
    if (psel && penable && pready) begin
      if (expq.size() == 0) chk("unexpected answer", 32'h0, 32'h1);
      else begin
        e = expq.pop_front();
        chk("pslverr", {31'h0, e.e}, {31'h0, pslverr});
        if (e.rd) chk("prdata", e.d, prdata);
      end
    end
  end

  // Writes a setting, then measures the period between the 2nd and 3rd rise; 0 means stopped
  task automatic cfg(input logic [15:0] idx, input logic [7:0] v, input int b, input int per);
    int t, r0, nr, got;
    logic p;
    apb(1'h1, idx, {24'h0, v}, 8'h0, 1'h0);
    got = 0;
    nr = 0;
    r0 = 0;
    p = ck[b];
    for (t = 0; t < 4 * per + 200 && nr < 3; t++) begin
      @(posedge pclk);
      if (ck[b] === 1'h1 && p === 1'h0) begin
        nr++;
        if (nr == 2) r0 = t;
        if (nr == 3) got = t - r0;
      end
      p = ck[b];
    end
    // Expected 1 stands for running at a rate that is left open
    if (per == 1) got = (got != 0) ? 1 : 0;
    chk("clock period", per, got);
  endtask

  task automatic glitch(input logic nmi, input int len, input logic exp_seen);
    int i;
    logic seen;
    seen = 1'h0;
    for (i = 0; i < len; i++) begin
      @(posedge pclk);
      if (nmi) nmi_in <= 1'h1;
      else ext_reset_n_in <= 1'h0;
    end
    @(posedge pclk);
    nmi_in <= 1'h0;
    ext_reset_n_in <= 1'h1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (nmi ? nmi_filtered === 1'h1 : reset_n_filtered === 1'h0) seen = 1'h1;
    end
    chk("filter pass", {31'h0, exp_seen}, {31'h0, seen});
  endtask

  task automatic edges_to(input int k);
    int i;
    for (i = 0; i < 8000 && main_edges < k; i++) @(posedge pclk);
    if (i == 8000) begin
      chk("edge wait", 32'h0, 32'h1);
      stop_test();
    end
  endtask

  initial begin
    int i, c, s;
    logic [31:0] d;
    void'($urandom(32'h20f77272));
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    for (i = 0; i < 8; i++) apb(1'h0, ia[i], 32'h0, ra[i], 1'h0);
    glitch(1'h1, 2, 1'h1);
    glitch(1'h0, 2, 1'h0);
    apb(1'h1, IDX_NFEN, 32'h01, 8'h0, 1'h0);
    glitch(1'h1, 2, 1'h0);
    glitch(1'h1, 8, 1'h1);
    glitch(1'h0, 2, 1'h1);
    apb(1'h0, 16'h5070, 32'h0, 8'h0, 1'h1);
    apb(1'h1, 16'h5070, 32'hff, 8'h0, 1'h1);
    for (i = 0; i < 8; i++) begin
      d = $urandom();
      if (i == 6) d[1:0] = {2{d[0]}};
      apb(1'h1, ia[i], d, 8'h0, 1'h0);
      apb(1'h0, ia[i], 32'h0, d[7:0] & ma[i], 1'h0);
    end
    for (c = 0; c < 4; c++) begin
      apb(1'h1, IDX_CTL, 32'h02, 8'h0, 1'h0);
      repeat (4) @(posedge pclk);
      chk("main_osc_enable", 32'h0, {31'h0, main_osc_enable});
      chk("main_osc_ready", 32'h0, {31'h0, main_osc_ready});
      apb(1'h1, IDX_CTL, {26'h0, c[1:0], 4'h3}, 8'h0, 1'h0);
      s = main_edges;
      edges_to(s + (1024 >> c) - 4);
      chk("main_osc_ready", 32'h0, {31'h0, main_osc_ready});
      edges_to(s + (1024 >> c) + 4);
      chk("main_osc_ready", 32'h1, {31'h0, main_osc_ready});
    end
    apb(1'h0, IDX_STAT, 32'h0, 8'h01, 1'h0);
    apb(1'h1, IDX_CTL, 32'h31, 8'h0, 1'h0);
    repeat (4) @(posedge pclk);
    chk("sub_osc_enable", 32'h0, {31'h0, sub_osc_enable});
    cfg(IDX_FOUT, 8'h01, 1, 0);
    apb(1'h1, IDX_CTL, 32'h33, 8'h0, 1'h0);
    repeat (4) @(posedge pclk);
    chk("sub_osc_enable", 32'h1, {31'h0, sub_osc_enable});
    cfg(IDX_FOUT, 8'h01, 1, 16);
    cfg(IDX_FOUT, 8'h00, 1, 0);
    for (i = 0; i < 3; i++) cfg(IDX_FOUT, {4'h0, i[1:0], 2'h2}, 2, 6 << i);
    cfg(IDX_FOUT, 8'h0e, 2, 0);
    cfg(IDX_FOUT, 8'h08, 2, 0);
    for (i = 0; i < 6; i++) cfg(IDX_TMR, {4'h0, i[2:0], 1'h1}, 0, 16 << i);
    cfg(IDX_TMR, 8'h0f, 0, 0);
    cfg(IDX_TMR, 8'h0a, 0, 0);
    for (i = 0; i < 5; i++) cfg(IDX_LCLK, {3'h0, i[2:0], 2'h1}, 3, 192 << i);
    cfg(IDX_LCLK, 8'h15, 3, 0);
    cfg(IDX_LCLK, 8'h03, 3, 16);
    cfg(IDX_LCLK, 8'h02, 3, 0);
    cfg(IDX_SRC, 8'h01, 6, 16);
    cfg(IDX_SRC, 8'h00, 6, 6);
    for (i = 0; i < 4; i++) cfg(IDX_CPU_CLOCK, {6'h0, i[1:0]}, 5, 6 << i);
    cfg(IDX_PCLK, 8'h00, 4, 0);
    cfg(IDX_PCLK, 8'h03, 4, 1);
    // Clock enable low must freeze every generated clock level
    ce <= 1'h0;
    @(posedge pclk);
    d = {25'h0, ck};
    repeat (20) @(posedge pclk);
    chk("frozen clocks", d, {25'h0, ck});
    ce <= 1'h1;
    stop_test();
  end

  initial begin
    #4000000;
    chk("run time", 32'h0, 32'h1);
    stop_test();
  end
endmodule
